/* common/pcicfg_pkg.sv */
// Constants for the bridge configuration header register bank.
// Assumes a 32-bit APB slave with byte addresses and one register per word.
package pcicfg_pkg;

  localparam logic [11:0] OFF_CLASS_REV   = 12'h008;
  localparam logic [11:0] OFF_HDR_MISC    = 12'h00c;
  localparam logic [11:0] OFF_WIN0_UNUSED = 12'h010;
  localparam logic [11:0] OFF_WIN1_BASE   = 12'h014;
  localparam logic [11:0] OFF_WIN2_BASE   = 12'h018;
  localparam logic [11:0] OFF_SUBSYS      = 12'h02c;
  localparam logic [11:0] OFF_CAP_PTR     = 12'h034;
  localparam logic [11:0] OFF_INT_LINE    = 12'h03c;
  localparam logic [11:0] OFF_STATUS      = 12'h004;
  localparam logic [11:0] OFF_WIN1_MASK   = 12'h100;
  localparam logic [11:0] OFF_WIN2_MASK   = 12'h104;
  localparam logic [11:0] OFF_BURST_CTRL  = 12'h108;

  localparam logic [23:0] CLASS_RESET     = 24'h06_0000;
  localparam logic [7:0]  BASE_CLASS_RST  = 8'h06;
  localparam logic [7:0]  CACHE_LINE_VAL  = 8'h00;
  localparam logic [2:0]  LAT_LOW_FIXED   = 3'b111;
  localparam logic [7:0]  LAT_RESET       = 8'h07;
  localparam logic [7:0]  HEADER_TYPE_VAL = 8'h00;
  localparam logic [7:0]  SELF_TEST_VAL   = 8'h00;
  localparam logic [7:0]  CAP_PTR_VAL     = 8'h58;
  localparam int          WIN_ADDR_LSB    = 12;
  localparam logic [3:0]  WIN_LOW_BITS    = 4'b1000;
  localparam int          STATUS_CAP_BIT  = 20;
  localparam logic [7:0]  ASYNC_LAT_LIMIT = 8'h40;
  localparam logic [19:0] WIN_MASK_RESET  = 20'h0_0000;

endpackage

/* rtl/pcicfg_regs.sv */
// Configuration header register bank of the host-to-PCI bridge, with APB access and
// the master latency timer that uses the programmed latency value.
// Assumes a single 250 MHz clock, APB master on the same clock, and the PCI
// master logic supplying burst and grant levels already synchronised.
// Writes commit at the APB access edge; read data is captured at setup.
// What this block does
// R1: Revision resets to macro revision, writable.
// R2: Class code resets 0x060000, stays writable.
// R3: Base class 23:16 resets 06, others zero.
// R4: Cache line size ignores writes, reads zero.
// R5: Latency low three bits fixed ones.
// R6: Lost grant in burst ends after latency.
// R7: Async mode may time out ignoring grant.
// R8: Header type reads zero, single function.
// R9: Self-test byte reads zero.
// R10: Offset 0x10 unused; windows start 0x14.
// R11: Window address bits writable where mask set.
// R12: Window bits 11:4 always zero.
// R13: Window bit3 one, bits 2:0 zero.
// R14: Masks programmed before PCI configures windows.
// R15: Disabled second window ignores writes, reads zero.
// R16: Software clears second window before disabling.
// R17: Capabilities pointer reads 0x58.
// R18: Two 16-bit subsystem identifier registers.
// R19: Interrupt line register stores routing byte.
// R20: Status capabilities-list flag always reads one.
`timescale 1ns/1ns
module pcicfg_regs
  import pcicfg_pkg::*;
#(
  // Arbitrary neutral value; stands for the macro revision number.
  parameter logic [7:0] REVISION_RESET = 8'h01
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        burst_active,
  input  wire logic        grant,
  output logic             latency_expired
);

  typedef struct packed {
    // Software-visible configuration state.
    logic [7:0]  revision_number;
    logic [23:0] class_code;
    logic [4:0]  latency_timer;
    logic [19:0] pci_window1_base;
    logic [19:0] pci_window2_base;
    logic [19:0] window1_size_mask;
    logic [19:0] window2_size_mask;
    logic        window2_mask_enable;
    logic [15:0] subsystem_vendor;
    logic [15:0] subsystem_ident;
    logic [7:0]  interrupt_routing;
    // Master latency counter.
    logic        async_mode;
    logic [7:0]  lat_count;
    logic        expired;
    // Registered bus answer.
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } pcicfg_state_t;

  pcicfg_state_t st_q;
  pcicfg_state_t st_d;

  logic        setup_phase;
  logic        access_phase;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic        hit;
  logic [7:0]  latency_full;
  logic [19:0] win1_wmask;
  logic [19:0] win2_wmask;
  logic        wr_class_rev;
  logic        wr_hdr_misc;
  logic        wr_win1_base;
  logic        wr_win2_base;
  logic        wr_subsys;
  logic        wr_int_line;
  logic        wr_win1_mask;
  logic        wr_win2_mask;
  logic        wr_burst_ctrl;
  logic [31:0] status_view;
  logic [31:0] class_view;
  logic [31:0] hdr_view;
  logic [31:0] win1_view;
  logic [31:0] win2_view;
  logic [31:0] subsys_view;
  logic [31:0] cap_view;
  logic [31:0] int_view;
  logic [31:0] mask1_view;
  logic [31:0] mask2_view;
  logic [31:0] burst_view;
  logic        count_enable;
  logic        count_zero;
  logic [7:0]  lat_next;
  logic        exp_next;

  assign setup_phase  = psel && !penable;
  assign rd_en        = setup_phase && !pwrite;
  // A write commits only at the edge at which the master samples pready, so a
  // transfer that never reaches its access phase leaves every register alone.
  assign access_phase = psel && penable && st_q.ready;
  assign wr_en        = access_phase && pwrite && hit;
  assign latency_full = {st_q.latency_timer, LAT_LOW_FIXED}; // see R5

  assign wr_class_rev  = wr_en && (paddr == OFF_CLASS_REV);
  assign wr_hdr_misc   = wr_en && (paddr == OFF_HDR_MISC);
  assign wr_win1_base  = wr_en && (paddr == OFF_WIN1_BASE);
  // Writes to the second window are dropped while it is disabled. see R15
  assign wr_win2_base  = wr_en && (paddr == OFF_WIN2_BASE) && st_q.window2_mask_enable;
  assign wr_subsys     = wr_en && (paddr == OFF_SUBSYS);
  assign wr_int_line   = wr_en && (paddr == OFF_INT_LINE);
  assign wr_win1_mask  = wr_en && (paddr == OFF_WIN1_MASK);
  assign wr_win2_mask  = wr_en && (paddr == OFF_WIN2_MASK);
  assign wr_burst_ctrl = wr_en && (paddr == OFF_BURST_CTRL);

  // Only address bits that the size mask opens, and whose lane is strobed,
  // take written data; closed bits keep reading zero. see R11
  assign win1_wmask = st_q.window1_size_mask & wmask[31:12];
  assign win2_wmask = st_q.window2_size_mask & wmask[31:12];

  // In async mode the count runs even while grant is held, which only costs
  // throughput, most visibly for values below ASYNC_LAT_LIMIT. see R6, R7
  assign count_enable = burst_active && (!grant || st_q.async_mode);
  assign count_zero   = (st_q.lat_count == 8'h00);

  // Counter next state: reload outside a burst, flag expiry one edge after zero.
  always_comb begin
    lat_next = st_q.lat_count;
    exp_next = st_q.expired;
    if (!burst_active) begin
      lat_next = latency_full;
      exp_next = 1'b0;
    end else if (count_enable) begin
      if (count_zero) begin
        exp_next = 1'b1;
      end else begin
        lat_next = st_q.lat_count - 8'h01;
      end
    end
  end

  always_comb begin
    wmask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // Read view of every mapped word.
  assign status_view = 32'h0000_0001 << STATUS_CAP_BIT; // see R20
  assign class_view  = {st_q.class_code, st_q.revision_number}; // see R1, R2
  // see R4, R5, R8, R9
  assign hdr_view    = {SELF_TEST_VAL, HEADER_TYPE_VAL, latency_full, CACHE_LINE_VAL};
  // see R11, R12, R13
  assign win1_view   = {st_q.pci_window1_base & st_q.window1_size_mask, 8'h00, WIN_LOW_BITS};
  // A disabled second window reads all zero, flag bits included. see R15
  assign win2_view   = st_q.window2_mask_enable
                     ? {st_q.pci_window2_base & st_q.window2_size_mask, 8'h00, WIN_LOW_BITS}
                     : 32'h0000_0000;
  assign subsys_view = {st_q.subsystem_ident, st_q.subsystem_vendor}; // see R18
  assign cap_view    = {24'h00_0000, CAP_PTR_VAL}; // see R17
  assign int_view    = {24'h00_0000, st_q.interrupt_routing}; // see R19
  assign mask1_view  = {st_q.window1_size_mask, 12'h000};
  assign mask2_view  = {st_q.window2_size_mask, 11'h000, st_q.window2_mask_enable};
  assign burst_view  = {22'h00_0000, st_q.expired, st_q.async_mode, st_q.lat_count};

  // Address decode; an unmapped word answers with an error and takes no write.
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      OFF_STATUS: begin
        rd_word = status_view;
      end
      OFF_CLASS_REV: begin
        rd_word = class_view;
      end
      OFF_HDR_MISC: begin
        rd_word = hdr_view;
      end
      OFF_WIN0_UNUSED: begin
        rd_word = 32'h0000_0000; // see R10
      end
      OFF_WIN1_BASE: begin
        rd_word = win1_view;
      end
      OFF_WIN2_BASE: begin
        rd_word = win2_view;
      end
      OFF_SUBSYS: begin
        rd_word = subsys_view;
      end
      OFF_CAP_PTR: begin
        rd_word = cap_view;
      end
      OFF_INT_LINE: begin
        rd_word = int_view;
      end
      OFF_WIN1_MASK: begin
        rd_word = mask1_view;
      end
      OFF_WIN2_MASK: begin
        rd_word = mask2_view;
      end
      OFF_BURST_CTRL: begin
        rd_word = burst_view;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_d        = st_q;
    st_d.ready  = setup_phase;
    st_d.slverr = setup_phase && !hit;
    if (rd_en) begin
      st_d.rdata = rd_word;
    end

    if (wr_class_rev) begin
      st_d.revision_number = (st_q.revision_number & ~wmask[7:0])
                           | (pwdata[7:0] & wmask[7:0]); // see R1
      st_d.class_code      = (st_q.class_code & ~wmask[31:8])
                           | (pwdata[31:8] & wmask[31:8]); // see R2, R3
    end

    // Only the five upper latency bits are stored; the low three read as ones.
    if (wr_hdr_misc && pstrb[1]) begin
      st_d.latency_timer = pwdata[15:11]; // see R5
    end

    if (wr_win1_base) begin
      st_d.pci_window1_base = (st_q.pci_window1_base & ~win1_wmask)
                            | (pwdata[31:12] & win1_wmask); // see R11
    end

    if (wr_win2_base) begin
      st_d.pci_window2_base = (st_q.pci_window2_base & ~win2_wmask)
                            | (pwdata[31:12] & win2_wmask); // see R11
    end

    if (wr_subsys) begin
      st_d.subsystem_vendor = (st_q.subsystem_vendor & ~wmask[15:0])
                            | (pwdata[15:0] & wmask[15:0]); // see R18
      st_d.subsystem_ident  = (st_q.subsystem_ident & ~wmask[31:16])
                            | (pwdata[31:16] & wmask[31:16]);
    end

    if (wr_int_line && pstrb[0]) begin
      st_d.interrupt_routing = pwdata[7:0]; // see R19
    end

    if (wr_win1_mask) begin
      // The mask must be set before a PCI agent sizes the window. see R14
      st_d.window1_size_mask = (st_q.window1_size_mask & ~wmask[31:12])
                             | (pwdata[31:12] & wmask[31:12]);
    end

    if (wr_win2_mask) begin
      st_d.window2_size_mask = (st_q.window2_size_mask & ~wmask[31:12])
                             | (pwdata[31:12] & wmask[31:12]);
      if (pstrb[0]) begin
        // Clearing the enable keeps the stored base; software zeroes it first. see R16
        st_d.window2_mask_enable = pwdata[0];
      end
    end

    if (wr_burst_ctrl && pstrb[1]) begin
      st_d.async_mode = pwdata[8];
    end

    st_d.lat_count = lat_next; // see R6, R7
    st_d.expired   = exp_next;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q                     <= '0;
      st_q.revision_number     <= REVISION_RESET; // see R1
      st_q.class_code          <= CLASS_RESET; // see R2, R3
      st_q.latency_timer       <= LAT_RESET[7:3];
      st_q.window1_size_mask   <= WIN_MASK_RESET;
      st_q.window2_size_mask   <= WIN_MASK_RESET;
      st_q.lat_count           <= LAT_RESET;
      // The second window starts disabled and the bus answer starts quiet.
      st_q.window2_mask_enable <= 1'b0;
      st_q.async_mode          <= 1'b0;
      st_q.expired             <= 1'b0;
      st_q.rdata               <= 32'h0000_0000;
      st_q.ready               <= 1'b0;
      st_q.slverr              <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata          = st_q.rdata;
  assign pready          = st_q.ready;
  assign pslverr         = st_q.slverr;
  assign latency_expired = st_q.expired;

endmodule

/* tb/pcicfg_chk.sv */
// Port assertions for the configuration register bank.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ns
module pcicfg_chk
  import pcicfg_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        burst_active,
  input wire logic        latency_expired
);
  logic rd;
  assign rd = psel & penable & pready & ~pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_cap_ptr: assert property (rd && paddr == OFF_CAP_PTR |-> prdata[7:0] == CAP_PTR_VAL)
    else $error("capability pointer wrong");
  a_hdr_fixed: assert property (rd && paddr == OFF_HDR_MISC |->
    prdata[31:16] == 16'h0000 && prdata[10:0] == 11'h700) else $error("fixed bytes wrong");
  a_win_low: assert property (rd && paddr == OFF_WIN1_BASE |-> prdata[11:0] == 12'h008)
    else $error("window low bits wrong");
  a_status_cap: assert property (rd && paddr == OFF_STATUS |-> prdata[STATUS_CAP_BIT])
    else $error("capability flag clear");
  a_unused_slot: assert property (rd && paddr == OFF_WIN0_UNUSED |-> prdata == 32'h0000_0000)
    else $error("unused slot not zero");
  a_expire_clear: assert property (!burst_active |=> !latency_expired)
    else $error("expiry outside burst");
  a_expire_burst: assert property ($rose(latency_expired) |-> $past(burst_active))
    else $error("expiry without burst");
endmodule
bind pcicfg_regs pcicfg_chk pcicfg_chk_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .burst_active(burst_active), .latency_expired(latency_expired));

/* tb/pcicfg_pci_model.sv */
// Stand-in for the PCI master logic that feeds burst and grant levels.
// Assumes the bench commands bursts on the bank's clock.
`timescale 1ns/1ns
module pcicfg_pci_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic hold_grant,
  output logic      burst_active,
  output logic      grant
);
  // Grant stays low for the whole burst unless held, which is what starts the timer.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      burst_active <= 1'b0;
      grant <= 1'b0;
    end else begin
      burst_active <= start;
      grant <= start & hold_grant;
    end
  end
endmodule

/* tb/tb_pci_config_header_regs.sv */
// Self-checking bench for the configuration register bank.
// Assumes the bank answers each APB transfer within a few cycles.
`timescale 1ns/1ns
module tb_pci_config_header_regs;
  import pcicfg_pkg::*;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, start = 0, hold = 0;
  logic [11:0] paddr = '0;
  logic [3:0]  strb = 4'hf;
  logic [31:0] pwdata = '0, x = 32'h0001_73ba, r, prdata;
  logic        pready, pslverr, burst_active, grant, latency_expired;
  logic [64:0] q[$], ne;
  int          n_errors = 0, check_count = 0;
  always #2 clk = ~clk;
  pcicfg_regs #(.REVISION_RESET(8'h3c)) pcicfg_regs_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .burst_active(burst_active), .grant(grant), .latency_expired(latency_expired));
  pcicfg_pci_model pcicfg_pci_model_inst (.clk(clk), .reset_n(reset_n), .start(start),
    .hold_grant(hold), .burst_active(burst_active), .grant(grant));
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic er = 1'b0);
    q.push_back({er, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  // The note is taken when the response is sampled, not when the read was issued.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ne = q.pop_front();
      chk({31'h0, pslverr}, {31'h0, ne[64]});
      chk(prdata & ne[63:32], ne[31:0]);
    end
  end
  task automatic burst(input logic h, input logic ex);
    int c;
    @(posedge clk);
    start <= 1'b1;
    hold <= h;
    c = 0;
    while (latency_expired !== 1'b1 && c < 20) begin
      @(posedge clk);
      c++;
    end
    chk({31'h0, c inside {[7:12]}}, {31'h0, ex});
    start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(OFF_CLASS_REV, '1, {CLASS_RESET, 8'h3c});
    r = rnd();
    apb(1'b1, OFF_CLASS_REV, r);
    rd(OFF_CLASS_REV, '1, r);
    rd(OFF_HDR_MISC, '1, 32'h0000_0700);
    apb(1'b1, OFF_HDR_MISC, r);
    rd(OFF_HDR_MISC, '1, {16'h0000, r[15:11], 3'b111, 8'h00});
    apb(1'b1, OFF_WIN0_UNUSED, r);
    rd(OFF_WIN0_UNUSED, '1, 32'h0000_0000);
    rd(OFF_WIN1_BASE, '1, 32'h0000_0008);
    apb(1'b1, OFF_WIN1_MASK, 32'hffff_0000);
    apb(1'b1, OFF_WIN1_BASE, r);
    rd(OFF_WIN1_BASE, '1, {r[31:16], 16'h0008});
    apb(1'b1, OFF_WIN2_BASE, r);
    rd(OFF_WIN2_BASE, '1, 32'h0000_0000);
    apb(1'b1, OFF_WIN2_MASK, 32'hffff_f001);
    apb(1'b1, OFF_WIN2_BASE, r);
    rd(OFF_WIN2_BASE, '1, {r[31:12], 12'h008});
    apb(1'b1, OFF_WIN2_BASE, 32'h0000_0000);
    apb(1'b1, OFF_WIN2_MASK, 32'hffff_f000);
    apb(1'b1, OFF_WIN2_BASE, r);
    rd(OFF_WIN2_BASE, '1, 32'h0000_0000);
    apb(1'b1, OFF_WIN2_MASK, 32'hffff_f001);
    rd(OFF_WIN2_BASE, '1, 32'h0000_0008);
    r = rnd();
    apb(1'b1, OFF_SUBSYS, r);
    rd(OFF_SUBSYS, '1, r);
    strb <= 4'h3;
    apb(1'b1, OFF_SUBSYS, ~r);
    strb <= 4'hf;
    rd(OFF_SUBSYS, '1, {r[31:16], ~r[15:0]});
    apb(1'b1, OFF_INT_LINE, r);
    rd(OFF_INT_LINE, 32'h0000_00ff, {24'h00_0000, r[7:0]});
    apb(1'b1, OFF_CAP_PTR, r);
    rd(OFF_CAP_PTR, 32'h0000_00ff, 32'h0000_0058);
    rd(OFF_STATUS, 32'h0010_0000, 32'h0010_0000);
    rd(12'h200, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b1, OFF_HDR_MISC, 32'h0000_0000);
    burst(1'b0, 1'b1);
    burst(1'b1, 1'b0);
    apb(1'b1, OFF_BURST_CTRL, 32'h0000_0100);
    burst(1'b1, 1'b1);
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule
